// ### src/dsa_frontend_ctrl.sv
// register file, clock dividers and decimator of the delta-sigma converter
module dsa_frontend_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic mod_bit,
   output logic conv_clk_pulse,
   output logic conversion_done,
   output dsa_pkg::dsa_analog_type analog
);
   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [7:0] power_control;
   logic [7:0] gain_ref_control;
   logic [7:0] input_connect_control;
   logic [7:0] input_channel_select;
   logic [7:0] filter_rate_control;
   logic [7:0] run_bits;
   logic [7:0] converter_clock_divider;
   logic [7:0] common_mode_buffer_control;
   logic [7:0] low_noise_amp_control;
   logic [23:0] result;
   logic [5:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_lane;
   logic wr_fire;
   logic done_set;
   logic [23:0] done_value;

   // ------------------------------------------------------------------
   // axi4-lite write channel
   // ------------------------------------------------------------------
   // both halves may arrive in either order; the write lands once both held
   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   function automatic logic mapped(input logic [5:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= dsa_pkg::OFF_LNA);
   endfunction : mapped

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= dsa_pkg::RESP_OKAY;
         wr_addr <= 6'h00;
         wr_data <= 8'h00;
         wr_lane <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            wr_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_data <= s_axi_wdata[7:0];
            wr_lane <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(wr_addr) ? dsa_pkg::RESP_OKAY : dsa_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // control register storage
   // ------------------------------------------------------------------
   logic wr_en;
   assign wr_en = wr_fire && wr_lane;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_control <= dsa_pkg::RST_POWER;
         gain_ref_control <= dsa_pkg::RST_GAIN_REF;
         input_connect_control <= dsa_pkg::RST_OTHER;
         input_channel_select <= dsa_pkg::RST_OTHER;
         filter_rate_control <= dsa_pkg::RST_OTHER;
         converter_clock_divider <= dsa_pkg::RST_OTHER;
         common_mode_buffer_control <= dsa_pkg::RST_CM_BUF;
         low_noise_amp_control <= dsa_pkg::RST_OTHER;
      end else if (wr_en) begin
         unique case (wr_addr)
            dsa_pkg::OFF_POWER: power_control <= wr_data & dsa_pkg::MASK_POWER;
            dsa_pkg::OFF_GAIN_REF: gain_ref_control <= wr_data;
            dsa_pkg::OFF_IN_CONNECT:
               input_connect_control <= wr_data & dsa_pkg::MASK_IN_CONNECT;
            dsa_pkg::OFF_IN_SELECT: input_channel_select <= wr_data;
            dsa_pkg::OFF_FILTER_RATE: filter_rate_control <= wr_data;
            dsa_pkg::OFF_CLK_DIV:
               converter_clock_divider <= wr_data & dsa_pkg::MASK_CLK_DIV;
            dsa_pkg::OFF_CM_BUF:
               common_mode_buffer_control <= wr_data & dsa_pkg::MASK_CM_BUF;
            dsa_pkg::OFF_LNA: low_noise_amp_control <= wr_data & dsa_pkg::MASK_LNA;
            default: ;
         endcase
      end
   end

   // run bits: hold, soft reset and enable stored; done handled below
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_bits <= dsa_pkg::RST_OTHER;
      end else if (wr_en && wr_addr == dsa_pkg::OFF_RUN) begin
         run_bits <= wr_data & dsa_pkg::MASK_RUN;
      end
   end

   // software clears by writing zero; a completion in the same cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conversion_done <= 1'b0;
      end else if (done_set) begin
         conversion_done <= 1'b1;
      end else if (wr_en && wr_addr == dsa_pkg::OFF_RUN && !wr_data[dsa_pkg::BIT_DONE]) begin
         conversion_done <= 1'b0;
      end
   end

   // all three bytes change in one edge so a read never sees a mix
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result <= 24'h00_0000;
      end else if (done_set) begin
         result <= done_value;
      end
   end

   // ------------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------------
   logic [7:0] rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      unique case (s_axi_araddr)
         dsa_pkg::OFF_POWER: rd_byte = power_control;
         dsa_pkg::OFF_GAIN_REF: rd_byte = gain_ref_control;
         dsa_pkg::OFF_IN_CONNECT: rd_byte = input_connect_control;
         dsa_pkg::OFF_IN_SELECT: rd_byte = input_channel_select;
         dsa_pkg::OFF_RES_LOW: rd_byte = result[7:0];
         dsa_pkg::OFF_RES_MID: rd_byte = result[15:8];
         dsa_pkg::OFF_RES_HIGH: rd_byte = result[23:16];
         dsa_pkg::OFF_FILTER_RATE: rd_byte = filter_rate_control;
         dsa_pkg::OFF_RUN: begin
            rd_byte = run_bits;
            rd_byte[dsa_pkg::BIT_DONE] = conversion_done;
         end
         dsa_pkg::OFF_CLK_DIV: rd_byte = converter_clock_divider;
         dsa_pkg::OFF_CM_BUF: rd_byte = common_mode_buffer_control;
         dsa_pkg::OFF_LNA: rd_byte = low_noise_amp_control;
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= dsa_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= mapped(s_axi_araddr) ? dsa_pkg::RESP_OKAY : dsa_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // converter clock dividers
   // ------------------------------------------------------------------
   logic conv_on;
   logic [5:0] src_cnt;
   logic [5:0] src_last;
   logic src_pulse;
   logic [4:0] n_cnt;
   logic [4:0] n_last;

   assign conv_on = run_bits[dsa_pkg::BIT_CONV_EN] && !run_bits[dsa_pkg::BIT_SOFT_RST];
   // 2*(div+1) system clocks per source pulse with BIT_SRC_SEL set, one clock otherwise
   assign src_last = {converter_clock_divider[4:0], 1'b1};
   assign src_pulse = !converter_clock_divider[dsa_pkg::BIT_SRC_SEL] || src_cnt == src_last;
   // reserved divide codes fall back to the longer divide
   assign n_last = (filter_rate_control[5:4] == dsa_pkg::DIVSEL_N12) ?
                   dsa_pkg::N_SHORT - 5'h01 : dsa_pkg::N_LONG - 5'h01;

   always_ff @(posedge aclk) begin
      if (!aresetn || !conv_on) begin
         src_cnt <= 6'h00;
      end else begin
         src_cnt <= src_pulse ? 6'h00 : src_cnt + 6'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !conv_on) begin
         n_cnt <= 5'h00;
         conv_clk_pulse <= 1'b0;
      end else begin
         conv_clk_pulse <= src_pulse && n_cnt == n_last;
         if (src_pulse) begin
            n_cnt <= (n_cnt == n_last) ? 5'h00 : n_cnt + 5'h01;
         end
      end
   end

   // ------------------------------------------------------------------
   // decimation filter
   // ------------------------------------------------------------------
   // a counting filter: sharper sinc responses are left to the analog
   // team's characterisation, only the word rate follows the order bit
   logic [3:0] osr_code;
   logic [4:0] log2_len;
   logic [16:0] len_last;
   logic [16:0] smp_cnt;
   logic [16:0] ones_cnt;
   logic [16:0] next_ones;
   logic [31:0] scaled;

   // reserved codes clamp to the shortest ratio
   assign osr_code = (filter_rate_control[3:0] > dsa_pkg::OSR_CODE_MAX) ?
                     dsa_pkg::OSR_CODE_MAX : filter_rate_control[3:0];
   assign log2_len = dsa_pkg::OSR_LOG2_TOP - {1'b0, osr_code}
                     + {4'h0, filter_rate_control[dsa_pkg::BIT_ORDER]};
   assign len_last = 17'((32'h1 << log2_len) - 32'h1);
   assign next_ones = ones_cnt + {16'h0000, mod_bit};
   assign scaled = 32'(next_ones) << (dsa_pkg::RESULT_BITS - log2_len);
   assign done_value = scaled[24] ? 24'hff_ffff : scaled[23:0];
   // a held result stays frozen and the flag untouched, counting goes on
   assign done_set = conv_clk_pulse && smp_cnt == len_last
                     && !run_bits[dsa_pkg::BIT_HOLD];

   always_ff @(posedge aclk) begin
      if (!aresetn || !conv_on) begin
         smp_cnt <= 17'h0_0000;
         ones_cnt <= 17'h0_0000;
      end else if (conv_clk_pulse) begin
         if (smp_cnt == len_last) begin
            smp_cnt <= 17'h0_0000;
            ones_cnt <= 17'h0_0000;
         end else begin
            smp_cnt <= smp_cnt + 17'h0_0001;
            ones_cnt <= next_ones;
         end
      end
   end

   // ------------------------------------------------------------------
   // analog front-end controls
   // ------------------------------------------------------------------
   logic pre_on;
   assign pre_on = gain_ref_control[dsa_pkg::BIT_PRE_EN];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         analog <= '0;
         analog.common_mode_amp_switch <= dsa_pkg::RST_CM_BUF[3:0];
         analog.converter_gain <= 2'h1;
      end else begin
         analog.regulator_level_sel <= power_control[1:0];
         analog.regulator_enable <= power_control[dsa_pkg::BIT_REG_EN];
         analog.bandgap_enable <= power_control[dsa_pkg::BIT_BANDGAP];
         analog.divider_enable <= power_control[dsa_pkg::BIT_DIVIDER];
         analog.temp_sensor_enable <= power_control[dsa_pkg::BIT_TEMP];
         analog.regulator_bypass <= power_control[dsa_pkg::BIT_REG_BYPASS];
         analog.common_mode_amp_enable <= common_mode_buffer_control[dsa_pkg::BIT_CM_EN];
         analog.common_mode_amp_switch <= common_mode_buffer_control[3:0];
         analog.ref_pair_sel <= gain_ref_control[7:6];
         analog.converter_gain <= gain_ref_control[dsa_pkg::BIT_CONV_GAIN] ?
                                  2'h2 : 2'h1;
         analog.preamp_enable <= pre_on;
         analog.preamp_bypass <= pre_on && gain_ref_control[dsa_pkg::BIT_PRE_BYPASS];
         analog.preamp_gain <= pre_on ? 8'h01 << gain_ref_control[2:0] : 8'h00;
         analog.pos_input_sel <= input_channel_select[3:0];
         analog.neg_input_sel <= input_channel_select[7:4];
         analog.input_connect <= input_connect_control[7:5];
         analog.low_noise_amp <= {low_noise_amp_control[7], low_noise_amp_control[2:0]};
      end
   end
endmodule : dsa_frontend_ctrl

// ### src/dsa_pkg.sv
// constants, register map and carrier types for the converter control block
package dsa_pkg;
   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam logic [5:0] OFF_POWER = 6'h00;
   localparam logic [5:0] OFF_GAIN_REF = 6'h04;
   localparam logic [5:0] OFF_IN_CONNECT = 6'h08;
   localparam logic [5:0] OFF_IN_SELECT = 6'h0c;
   localparam logic [5:0] OFF_RES_LOW = 6'h10;
   localparam logic [5:0] OFF_RES_MID = 6'h14;
   localparam logic [5:0] OFF_RES_HIGH = 6'h18;
   localparam logic [5:0] OFF_FILTER_RATE = 6'h1c;
   localparam logic [5:0] OFF_RUN = 6'h20;
   localparam logic [5:0] OFF_CLK_DIV = 6'h24;
   localparam logic [5:0] OFF_CM_BUF = 6'h28;
   localparam logic [5:0] OFF_LNA = 6'h2c;
   // ------------------------------------------------------------------
   // implemented-bit masks and reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] MASK_POWER = 8'hdf;
   localparam logic [7:0] MASK_IN_CONNECT = 8'he0;
   localparam logic [7:0] MASK_RUN = 8'h3c;
   localparam logic [7:0] MASK_CLK_DIV = 8'h9f;
   localparam logic [7:0] MASK_CM_BUF = 8'h8f;
   localparam logic [7:0] MASK_LNA = 8'h87;
   localparam logic [7:0] RST_POWER = 8'h00;
   localparam logic [7:0] RST_GAIN_REF = 8'h00;
   localparam logic [7:0] RST_CM_BUF = 8'h0a;
   localparam logic [7:0] RST_OTHER = 8'h00;
   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int BIT_REG_EN = 7;
   localparam int BIT_BANDGAP = 6;
   localparam int BIT_DIVIDER = 4;
   localparam int BIT_TEMP = 3;
   localparam int BIT_REG_BYPASS = 2;
   localparam int BIT_CM_EN = 7;
   localparam int BIT_CONV_GAIN = 5;
   localparam int BIT_PRE_EN = 4;
   localparam int BIT_PRE_BYPASS = 3;
   localparam int BIT_ORDER = 7;
   localparam int BIT_HOLD = 5;
   localparam int BIT_DONE = 4;
   localparam int BIT_SOFT_RST = 3;
   localparam int BIT_CONV_EN = 2;
   localparam int BIT_SRC_SEL = 7;
   // ------------------------------------------------------------------
   // rate arithmetic and bus response codes
   // ------------------------------------------------------------------
   localparam logic [1:0] DIVSEL_N30 = 2'h0;
   localparam logic [1:0] DIVSEL_N12 = 2'h2;
   localparam logic [4:0] N_LONG = 5'h1e;
   localparam logic [4:0] N_SHORT = 5'h0c;
   localparam logic [3:0] OSR_CODE_MAX = 4'h8;
   localparam logic [4:0] OSR_LOG2_TOP = 5'h0f;
   localparam logic [4:0] RESULT_BITS = 5'h18;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] regulator_level_sel;
      logic regulator_enable;
      logic bandgap_enable;
      logic divider_enable;
      logic temp_sensor_enable;
      logic regulator_bypass;
      logic common_mode_amp_enable;
      logic [3:0] common_mode_amp_switch;
      logic [1:0] ref_pair_sel;
      logic [1:0] converter_gain;
      logic preamp_enable;
      logic preamp_bypass;
      logic [7:0] preamp_gain;
      logic [3:0] pos_input_sel;
      logic [3:0] neg_input_sel;
      logic [2:0] input_connect;
      logic [3:0] low_noise_amp;
   } dsa_analog_type;
endpackage : dsa_pkg

// ### tb/dsa_frontend_ctrl_chk.sv
// concurrent assertions on the converter control block ports
module dsa_frontend_ctrl_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic conv_clk_pulse,
   input wire logic conversion_done,
   input wire dsa_pkg::dsa_analog_type analog
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------------
   // recent software clears of the done flag
   // ------------------------------------------------------------------
   logic [3:0] clr_hist;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clr_hist <= 4'h0;
      end else begin
         clr_hist <= {clr_hist[2:0], s_axi_awvalid && s_axi_awready
            && s_axi_awaddr == dsa_pkg::OFF_RUN && !s_axi_wdata[dsa_pkg::BIT_DONE]};
      end
   end
   // ------------------------------------------------------------------
   // properties
   // ------------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   sequence s_quiet; !conv_clk_pulse [*8]; endsequence
   // the write lands one edge after the take, and the answer rises at that same edge
   property p_wr_answer; s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
   property p_wr_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_wr_busy: assert property (p_wr_busy) else $error("second write accepted");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("bad read answer");
   property p_pulse_gap; conv_clk_pulse |=> s_quiet; endproperty
   a_pulse_gap: assert property (p_pulse_gap) else $error("converter pulses too close");
   property p_done_sticky; $fell(conversion_done) |-> |clr_hist; endproperty
   a_done_sticky: assert property (p_done_sticky) else $error("done cleared alone");
   property p_preamp_gate;
      !analog.preamp_enable |-> analog.preamp_gain == 8'h00 && !analog.preamp_bypass;
   endproperty
   a_preamp_gate: assert property (p_preamp_gate) else $error("preamp active while off");
   property p_gain_pow; analog.preamp_enable |-> $onehot(analog.preamp_gain); endproperty
   a_gain_pow: assert property (p_gain_pow) else $error("preamp gain not a power of two");
   property p_conv_gain; analog.converter_gain inside {2'h1, 2'h2}; endproperty
   a_conv_gain: assert property (p_conv_gain) else $error("bad converter gain");
   property p_rst_state;
      $rose(aresetn) |-> analog.common_mode_amp_switch == 4'ha && !conversion_done
         && analog.regulator_level_sel == 2'h0 && !analog.regulator_enable;
   endproperty
   a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
endmodule : dsa_frontend_ctrl_chk
bind dsa_frontend_ctrl dsa_frontend_ctrl_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .conv_clk_pulse(conv_clk_pulse),
   .conversion_done(conversion_done), .analog(analog));

// ### tb/dsa_mod_model.sv
// modulator bit stream model for the converter control block
module dsa_mod_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic conv_clk_pulse,
   input wire logic [1:0] pattern,
   output logic mod_bit
);
   timeunit 1ns;
   timeprecision 1ns;
   logic phase;
   // phase flips per converter clock; only pattern 1 follows it, patterns 0 and 2 give a frozen stream
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase <= 1'h0;
      end else if (conv_clk_pulse) begin
         phase <= !phase;
      end
   end
   // 0 all ones, 1 alternating, 2 all zeros
   assign mod_bit = (pattern == 2'h0) || (pattern == 2'h1 && phase);
endmodule : dsa_mod_model

// ### tb/tb.sv
// self-checking bench for the converter control block
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, mod_bit, pulse, done;
   logic awready, wready, bvalid, arready, rvalid;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, pattern;
   dsa_pkg::dsa_analog_type analog;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   int gap;
   logic [5:0] offs [7] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h1c, 6'h28, 6'h2c};
   logic [7:0] rst [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h00};
   logic [7:0] msk [7] = '{8'hdf, 8'hff, 8'he0, 8'hff, 8'hff, 8'h8f, 8'h87};
   dsa_frontend_ctrl u_dsa_frontend_ctrl (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .mod_bit(mod_bit), .conv_clk_pulse(pulse), .conversion_done(done), .analog(analog));
   dsa_mod_model u_dsa_mod_model (.aclk(aclk), .aresetn(aresetn), .conv_clk_pulse(pulse),
      .pattern(pattern), .mod_bit(mod_bit));
   initial begin
      aclk = 1'h0;
      forever #50 aclk = !aclk;
   end
   always @(posedge aclk) cyc <= cyc + 1;
   // ------------------------------------------------------------------
   // bus and compare tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic err);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      @(posedge aclk);
      while (!bvalid) begin
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         @(posedge aclk);
      end
      bready <= 1'h0;
      chk(32'(bresp), err ? 32'(dsa_pkg::RESP_SLVERR) : 32'(dsa_pkg::RESP_OKAY));
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic err);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      @(posedge aclk);
      while (!rvalid) begin
         if (arready) arvalid <= 1'h0;
         @(posedge aclk);
      end
      rready <= 1'h0;
      chk(rdata, ed);
      chk(32'(rresp), err ? 32'(dsa_pkg::RESP_SLVERR) : 32'(dsa_pkg::RESP_OKAY));
   endtask : rd
   task automatic pulse_gap(output int g);
      repeat (300) @(posedge aclk);
      while (!pulse) @(posedge aclk);
      g = 0;
      do begin
         @(posedge aclk);
         g++;
      end while (!pulse);
   endtask : pulse_gap
   // clear done, then time two successive done rises
   task automatic period(output int p);
      int t1;
      wr(dsa_pkg::OFF_RUN, 8'h04, 1'h0);
      repeat (2) @(posedge aclk);
      while (!done) @(posedge aclk);
      t1 = cyc;
      wr(dsa_pkg::OFF_RUN, 8'h04, 1'h0);
      repeat (2) @(posedge aclk);
      while (!done) @(posedge aclk);
      p = cyc - t1;
   endtask : period
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, wstrb, pattern} = {12'h000, 32'h0000_0000, 4'hf, 2'h1};
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      for (int i = 0; i < 7; i++) begin
         rd(offs[i], {24'h00_0000, rst[i]}, 1'h0);
         wr(offs[i], 8'hff, 1'h0);
         rd(offs[i], {24'h00_0000, msk[i]}, 1'h0);
      end
      chk(32'({analog.regulator_level_sel, analog.regulator_enable, analog.bandgap_enable,
         analog.divider_enable, analog.temp_sensor_enable, analog.regulator_bypass}), 32'h7f);
      chk(32'({analog.common_mode_amp_enable, analog.common_mode_amp_switch, analog.ref_pair_sel,
         analog.converter_gain, analog.preamp_bypass, analog.preamp_gain}), 32'h3_fd80);
      chk(32'({analog.pos_input_sel, analog.neg_input_sel, analog.input_connect,
         analog.low_noise_amp}), 32'h7fff);
      for (int c = 0; c < 8; c++) begin
         wr(dsa_pkg::OFF_GAIN_REF, {c[1:0], c[0], 2'h2, c[2:0]}, 1'h0);
         repeat (2) @(posedge aclk);
         chk(32'({analog.ref_pair_sel, analog.converter_gain, analog.preamp_gain}),
            32'({c[1:0], c[0] ? 2'h2 : 2'h1, 8'h01 << c}));
      end
      wr(dsa_pkg::OFF_GAIN_REF, 8'h0f, 1'h0);
      repeat (2) @(posedge aclk);
      chk(32'({analog.preamp_bypass, analog.preamp_gain}), 32'h0);
      wr(6'h30, 8'h55, 1'h1);
      rd(6'h05, 32'h0, 1'h1);
      wr(dsa_pkg::OFF_RES_LOW, 8'hff, 1'h0);
      rd(dsa_pkg::OFF_RES_LOW, 32'h0, 1'h0);
      wstrb <= 4'h0;
      wr(dsa_pkg::OFF_POWER, 8'h00, 1'h0);
      wstrb <= 4'hf;
      rd(dsa_pkg::OFF_POWER, 32'hdf, 1'h0);
      wr(dsa_pkg::OFF_CLK_DIV, 8'h00, 1'h0);
      wr(dsa_pkg::OFF_FILTER_RATE, 8'h28, 1'h0);
      wr(dsa_pkg::OFF_RUN, 8'h04, 1'h0);
      pulse_gap(gap);
      chk(32'(gap), 32'd12);
      period(gap);
      chk(32'(gap), 32'd1536);
      rd(dsa_pkg::OFF_RUN, 32'h14, 1'h0);
      rd(dsa_pkg::OFF_RES_HIGH, 32'h80, 1'h0);
      rd(dsa_pkg::OFF_RES_MID, 32'h00, 1'h0);
      rd(dsa_pkg::OFF_RES_LOW, 32'h00, 1'h0);
      wr(dsa_pkg::OFF_FILTER_RATE, 8'ha8, 1'h0);
      period(gap);
      chk(32'(gap), 32'd3072);
      pattern <= 2'h2;
      wr(dsa_pkg::OFF_RUN, 8'h24, 1'h0);
      repeat (3200) @(posedge aclk);
      rd(dsa_pkg::OFF_RUN, 32'h24, 1'h0);
      rd(dsa_pkg::OFF_RES_HIGH, 32'h80, 1'h0);
      period(gap);
      rd(dsa_pkg::OFF_RES_HIGH, 32'h00, 1'h0);
      wr(dsa_pkg::OFF_CLK_DIV, 8'h81, 1'h0);
      pulse_gap(gap);
      chk(32'(gap), 32'd48);
      wr(dsa_pkg::OFF_FILTER_RATE, 8'h08, 1'h0);
      pulse_gap(gap);
      chk(32'(gap), 32'd120);
      close_out();
   end
   // run is about 20000 cycles
   initial begin
      repeat (60000) @(posedge aclk);
      n_errors++;
      close_out();
   end
endmodule : tb
